// >>> src/osl_defines.svh
`ifndef OSL_DEFINES_SVH
`define OSL_DEFINES_SVH
`define OSL_OFS_EBIT_HIGH 5'h10
`define OSL_OFS_EBIT_LOW 5'h11
`define OSL_OFS_FAS 5'h12
`define OSL_OFS_BPV_HIGH 5'h13
`define OSL_OFS_BPV_LOW 5'h14
`define OSL_OFS_CRC_HIGH 5'h15
`define OSL_OFS_CRC_LOW 5'h16
`define OSL_EBIT_WIDTH 10
`define OSL_FAS_WIDTH 8
`define OSL_BPV_WIDTH 16
`define OSL_CRC_WIDTH 10
`define OSL_TICK_PERIOD_NS 1000000000
`define OSL_CLOCK_PERIOD_NS 25
`define OSL_TICK_CYCLES (`OSL_TICK_PERIOD_NS / `OSL_CLOCK_PERIOD_NS)
`endif

// >>> src/osl_pkg.sv
`default_nettype none
package osl_pkg;
  typedef logic [7:0] osl_byte_t;
  typedef logic [4:0] osl_addr_t;
endpackage : osl_pkg
`default_nettype wire

// >>> src/osl_counter.sv
`include "osl_defines.svh"
`default_nettype none
module osl_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic incr_in,
  output logic [WIDTH-1:0] latched_out
);
  logic [WIDTH-1:0] run_q;
  logic [WIDTH-1:0] run_d;
  logic [WIDTH-1:0] lat_q;
  logic [WIDTH-1:0] lat_d;

  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("osl_counter width out of range");
  end

  always_comb begin
    lat_d = lat_q;
    run_d = run_q;
    if (tick_in) begin
      lat_d = run_q;
      run_d = incr_in ? WIDTH'(1) : '0;
    end else if (incr_in && run_q != '1) begin
      run_d = run_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_q <= '0;
      lat_q <= '0;
    end else begin
      run_q <= run_d;
      lat_q <= lat_d;
    end
  end

  assign latched_out = lat_q;

  property p_hold;
    @(posedge clock_in) disable iff (!rst_n_in)
      !tick_in |=> $stable(lat_q);
  endproperty
  a_hold: assert property (p_hold) else $error("latched value moved between ticks");

  property p_restart;
    @(posedge clock_in) disable iff (!rst_n_in)
      tick_in |=> (lat_q == $past(run_q)) && (run_q == WIDTH'($past(incr_in)));
  endproperty
  a_restart: assert property (p_restart) else $error("tick did not latch and restart");
endmodule : osl_counter
`default_nettype wire

// >>> src/osl_bank.sv
// Notes on behaviour
// - E-bit error latch is 10 bits: upper two at 0x10, lower eight at 0x11.
// - Each latch loads from its counter once per second, constant between ticks.
// - 8-bit errored frame alignment count increments per bad FAS, read at 0x12.
// - 16-bit bipolar violation count: high byte 0x13, low byte 0x14.
// - 10-bit CRC-4 error latch: upper two bits 0x15, lower eight 0x16.
`include "osl_defines.svh"
`default_nettype none
module osl_bank
  import osl_pkg::*;
#(
  parameter int TICK_CYCLES = `OSL_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Error event pulses, same clock
  input wire logic ebit_err_in,
  input wire logic fas_err_in,
  input wire logic bpv_err_in,
  input wire logic crc_err_in,
  // Register read port
  input wire logic rd_en_in,
  input wire logic [4:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  // One-second tick
  output logic tick_out
);
  logic rst_s1_q;
  logic rst_s2_q;
  logic [31:0] tmr_q;
  logic [31:0] tmr_d;
  logic tick_q;
  logic tick_d;
  osl_byte_t rd_q;
  osl_byte_t rd_d;
  logic [`OSL_EBIT_WIDTH-1:0] ebit_lat;
  logic [`OSL_FAS_WIDTH-1:0] fas_lat;
  logic [`OSL_BPV_WIDTH-1:0] bpv_lat;
  logic [`OSL_CRC_WIDTH-1:0] crc_lat;

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // Two-flop release of the asynchronous reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Free-running one-second timer
  always_comb begin
    tick_d = 1'b0;
    tmr_d = tmr_q + 32'h1;
    if (tmr_q == 32'(TICK_CYCLES - 1)) begin
      tmr_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      tmr_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tmr_q <= tmr_d;
      tick_q <= tick_d;
    end
  end

  osl_counter #(.WIDTH(`OSL_EBIT_WIDTH)) u_ebit (
    .clock_in(clock_in), .rst_n_in(rst_s2_q), .tick_in(tick_q),
    .incr_in(ebit_err_in), .latched_out(ebit_lat));
  osl_counter #(.WIDTH(`OSL_FAS_WIDTH)) u_fas (
    .clock_in(clock_in), .rst_n_in(rst_s2_q), .tick_in(tick_q),
    .incr_in(fas_err_in), .latched_out(fas_lat));
  osl_counter #(.WIDTH(`OSL_BPV_WIDTH)) u_bpv (
    .clock_in(clock_in), .rst_n_in(rst_s2_q), .tick_in(tick_q),
    .incr_in(bpv_err_in), .latched_out(bpv_lat));
  osl_counter #(.WIDTH(`OSL_CRC_WIDTH)) u_crc (
    .clock_in(clock_in), .rst_n_in(rst_s2_q), .tick_in(tick_q),
    .incr_in(crc_err_in), .latched_out(crc_lat));

  // Registered read mux; holds its value while idle
  always_comb begin
    rd_d = rd_q;
    if (rd_en_in) begin
      if (rd_addr_in == `OSL_OFS_EBIT_HIGH) begin
        rd_d = {6'h00, ebit_lat[9:8]};
      end else if (rd_addr_in == `OSL_OFS_EBIT_LOW) begin
        rd_d = ebit_lat[7:0];
      end else if (rd_addr_in == `OSL_OFS_FAS) begin
        rd_d = fas_lat;
      end else if (rd_addr_in == `OSL_OFS_BPV_HIGH) begin
        rd_d = bpv_lat[15:8];
      end else if (rd_addr_in == `OSL_OFS_BPV_LOW) begin
        rd_d = bpv_lat[7:0];
      end else if (rd_addr_in == `OSL_OFS_CRC_HIGH) begin
        rd_d = {6'h00, crc_lat[9:8]};
      end else if (rd_addr_in == `OSL_OFS_CRC_LOW) begin
        rd_d = crc_lat[7:0];
      end else begin
        rd_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data_out = rd_q;
  assign tick_out = tick_q;

  sequence s_read_ebit_hi;
    rd_en_in && rd_addr_in == `OSL_OFS_EBIT_HIGH;
  endsequence
  property p_ebit_hi;
    @(posedge clock_in) disable iff (!rst_s2_q)
      s_read_ebit_hi |=> rd_q == {6'h00, $past(ebit_lat[9:8])};
  endproperty
  a_ebit_hi: assert property (p_ebit_hi) else $error("E-bit high read wrong");

  property p_fas;
    @(posedge clock_in) disable iff (!rst_s2_q)
      rd_en_in && rd_addr_in == `OSL_OFS_FAS |=> rd_q == $past(fas_lat);
  endproperty
  a_fas: assert property (p_fas) else $error("FAS read wrong");

  property p_bpv;
    @(posedge clock_in) disable iff (!rst_s2_q)
      rd_en_in && rd_addr_in == `OSL_OFS_BPV_HIGH |=> rd_q == $past(bpv_lat[15:8]);
  endproperty
  a_bpv: assert property (p_bpv) else $error("BPV high read wrong");

  property p_crc;
    @(posedge clock_in) disable iff (!rst_s2_q)
      rd_en_in && rd_addr_in == `OSL_OFS_CRC_LOW |=> rd_q == $past(crc_lat[7:0]);
  endproperty
  a_crc: assert property (p_crc) else $error("CRC low read wrong");

  property p_tick_once;
    @(posedge clock_in) disable iff (!rst_s2_q)
      tick_q |=> !tick_q;
  endproperty
  a_tick_once: assert property (p_tick_once) else $error("tick longer than one cycle");

  sequence s_read_ebit_lo;
    rd_en_in && rd_addr_in == `OSL_OFS_EBIT_LOW;
  endsequence
  property p_ebit_lo;
    @(posedge clock_in) disable iff (!rst_s2_q)
      s_read_ebit_lo |=> rd_q == $past(ebit_lat[7:0]);
  endproperty
  a_ebit_lo: assert property (p_ebit_lo) else $error("E-bit low read wrong");

  sequence s_read_bpv_lo;
    rd_en_in && rd_addr_in == `OSL_OFS_BPV_LOW;
  endsequence
  property p_bpv_lo;
    @(posedge clock_in) disable iff (!rst_s2_q)
      s_read_bpv_lo |=> rd_q == $past(bpv_lat[7:0]);
  endproperty
  a_bpv_lo: assert property (p_bpv_lo) else $error("BPV low read wrong");

  sequence s_read_crc_hi;
    rd_en_in && rd_addr_in == `OSL_OFS_CRC_HIGH;
  endsequence
  property p_crc_hi;
    @(posedge clock_in) disable iff (!rst_s2_q)
      s_read_crc_hi |=> rd_q == {6'h00, $past(crc_lat[9:8])};
  endproperty
  a_crc_hi: assert property (p_crc_hi) else $error("CRC high read wrong");

  // Addresses outside the bank read as zero
  sequence s_read_unmapped;
    rd_en_in && (rd_addr_in < `OSL_OFS_EBIT_HIGH || rd_addr_in > `OSL_OFS_CRC_LOW);
  endsequence
  property p_unmapped;
    @(posedge clock_in) disable iff (!rst_s2_q)
      s_read_unmapped |=> rd_q == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_rd_idle;
    @(posedge clock_in) disable iff (!rst_s2_q)
      !rd_en_in |=> $stable(rd_q);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data moved without a read");

  property p_rd_reset;
    @(posedge clock_in) disable iff (!rst_s2_q)
      $rose(rst_s2_q) |-> rd_q == 8'h00 && !tick_q;
  endproperty
  a_rd_reset: assert property (p_rd_reset) else $error("outputs not clear after reset");

  property p_tick_at_wrap;
    @(posedge clock_in) disable iff (!rst_s2_q)
      tmr_q == 32'(TICK_CYCLES - 1) |=> tick_q && tmr_q == 32'h0;
  endproperty
  a_tick_at_wrap: assert property (p_tick_at_wrap) else $error("no tick at timer wrap");

  property p_tick_spaced;
    @(posedge clock_in) disable iff (!rst_s2_q)
      tick_q |-> tmr_q == 32'h0;
  endproperty
  a_tick_spaced: assert property (p_tick_spaced) else $error("tick off the timer wrap");

  property p_tmr_range;
    @(posedge clock_in) disable iff (!rst_s2_q)
      tmr_q < 32'(TICK_CYCLES);
  endproperty
  a_tmr_range: assert property (p_tmr_range) else $error("timer beyond its period");
endmodule : osl_bank
`default_nettype wire

// >>> test/osl_testbench.sv
`default_nettype none
module testbench
  import osl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 300;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ebit_err_in = 1'b0;
  logic fas_err_in = 1'b0;
  logic bpv_err_in = 1'b0;
  logic crc_err_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [4:0] rd_addr_in = 5'h00;
  logic [7:0] rd_data_out;
  logic tick_out;
  int n_fail = 0;
  int n_compared = 0;
  osl_bank #(.TICK_CYCLES(TICKS)) dut (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ebit_err_in(ebit_err_in),
    .fas_err_in(fas_err_in),
    .bpv_err_in(bpv_err_in),
    .crc_err_in(crc_err_in),
    .rd_en_in(rd_en_in),
    .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out),
    .tick_out(tick_out)
  );
  always #12.5 clock_in = ~clock_in;
  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_tick();
    for (int n = 0; n < 400; n++) begin
      @(negedge clock_in);
      if (tick_out === 1'b1) return;
    end
    n_fail++;
    $display("ERROR %0t no tick seen", $time);
  endtask : wait_tick
  // Strobe stays high; caller lowers it after the last read
  task automatic rd(input osl_addr_t a, input osl_byte_t exp);
    rd_en_in = 1'b1;
    rd_addr_in = a;
    @(negedge clock_in);
    check(rd_data_out, exp);
  endtask : rd
  // Large counts, split halves, unmapped reads, constant latch
  task automatic test_counts();
    wait_tick();
    for (int i = 0; i < 260; i++) begin
      ebit_err_in = 1'b1;
      crc_err_in = (i < 259);
      bpv_err_in = (i < 258);
      fas_err_in = (i < 5);
      @(negedge clock_in);
    end
    {ebit_err_in, crc_err_in, bpv_err_in, fas_err_in} = 4'h0;
    wait_tick();
    @(negedge clock_in);
    bpv_err_in = 1'b1;
    rd(5'h10, 8'h01);
    rd(5'h11, 8'h04);
    rd(5'h12, 8'h05);
    bpv_err_in = 1'b0;
    rd(5'h13, 8'h01);
    rd(5'h14, 8'h02);
    rd(5'h15, 8'h01);
    rd(5'h16, 8'h03);
    rd(5'h17, 8'h00);
    rd(5'h0F, 8'h00);
    rd(5'h14, 8'h02);
    rd_en_in = 1'b0;
  endtask : test_counts
  // Counters restart at the tick; new interval only
  task automatic test_restart();
    wait_tick();
    @(negedge clock_in);
    check(rd_data_out, 8'h02);
    rd(5'h13, 8'h00);
    rd(5'h14, 8'h03);
    rd(5'h12, 8'h00);
    rd(5'h11, 8'h00);
    rd(5'h1F, 8'h00);
    rd_en_in = 1'b0;
  endtask : test_restart
  // Mid-run reset clears read data and latches
  task automatic test_reset();
    @(negedge clock_in);
    rd(5'h14, 8'h03);
    rd_en_in = 1'b0;
    rst_n_in = 1'b0;
    @(negedge clock_in);
    check(rd_data_out, 8'h00);
    check(tick_out, 1'b0);
    rst_n_in = 1'b1;
    repeat (2) @(negedge clock_in);
    rd(5'h14, 8'h00);
    rd(5'h10, 8'h00);
    rd_en_in = 1'b0;
  endtask : test_reset
  // Tick is one cycle wide and TICKS cycles apart
  task automatic test_tick();
    int gap;
    wait_tick();
    @(negedge clock_in);
    check(tick_out, 1'b0);
    gap = 1;
    while (tick_out !== 1'b1 && gap < 400) begin
      @(negedge clock_in);
      gap++;
    end
    check(gap, TICKS);
  endtask : test_tick
  initial begin
    repeat (4) @(negedge clock_in);
    rst_n_in = 1'b1;
    test_counts();
    test_restart();
    test_reset();
    test_tick();
    give_verdict();
  end
  initial begin
    #150us;
    n_fail++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
